// ===== rtl/rtc_regs.sv
// Operation
// - Select bit picks word A or B
// - Bit four powers down transmit path
// - Bit three powers down synthesiser
// - Bit two powers down oscillator core
// - Bit one powers down bias, buffer
// - Reset bit low loads other defaults
// - Main register takes written values only
// - Word A three bytes with defaults
// - Word B three bytes with defaults
// - Eleven-bit deviation across two registers
// - Oscillator core current nibble, default 1100
// - Buffer drive field, default 10
// - Crystal bypass bit, default zero
// - High array level, default 0000
// - Low array level, default 1111
// - Frequency words written independently
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module rtc_regs (
    input  wire logic              mclk_in,      // 25 MHz clock
    input  wire logic              rst_in,       // Synchronous reset, high
    input  wire logic [7:0]        addr_in,      // Register offset
    input  wire logic [7:0]        wdata_in,     // Write data
    input  wire logic              wr_in,        // Write strobe
    input  wire logic              rd_in,        // Read strobe
    output logic [7:0]             rdata_out,    // Read data, cycle after strobe
    output rtc_pkg::rtc_ctrl_t     ctrl_out      // Controls to analogue blocks
);
    // ======================================================================
    // Storage
    // ======================================================================
    logic [7:0] main_q;                 // Main control
    logic [7:0] cfg_q [1:11];           // Registers 01h..0Bh
    logic [7:0] rdata_q;                // Read data holding register
    logic [7:0] rd_mux;                 // Combinational read select
    logic       soft_rst;               // Default load request

    // Soft reset is a write of main with its reset bit low
    assign soft_rst = wr_in && (addr_in == rtc_pkg::ADDR_MAIN)
                      && !wdata_in[rtc_pkg::MAIN_RSTN_BIT];

    // ======================================================================
    // Main control register
    // ======================================================================
    // Only the bus writes it; the soft reset never touches it
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            main_q <= rtc_pkg::RST_MAIN;
        end else if (wr_in && addr_in == rtc_pkg::ADDR_MAIN) begin
            main_q <= wdata_in & rtc_pkg::MAIN_MASK;
        end
    end

    // ======================================================================
    // Configuration registers 01h..0Bh
    // ======================================================================
    // Per-register default and writable-bit mask
    function automatic logic [7:0] dflt(input int i);
        case (i)
            1:       dflt = rtc_pkg::RST_A_HIGH;
            2:       dflt = rtc_pkg::RST_A_MID;
            3:       dflt = rtc_pkg::RST_A_LOW;
            4:       dflt = rtc_pkg::RST_B_HIGH;
            5:       dflt = rtc_pkg::RST_B_MID;
            6:       dflt = rtc_pkg::RST_B_LOW;
            7:       dflt = rtc_pkg::RST_DEV_HI;
            8:       dflt = rtc_pkg::RST_DEV_LO;
            9:       dflt = rtc_pkg::RST_BIAS;
            10:      dflt = rtc_pkg::RST_CRYSTAL_OSC_CTRL;
            default: dflt = rtc_pkg::RST_POWER;
        endcase
    endfunction

    function automatic logic [7:0] wmask(input int i);
        case (i)
            7:       wmask = rtc_pkg::DEVHI_MASK;
            9:       wmask = rtc_pkg::BIAS_MASK;
            10:      wmask = rtc_pkg::CRYSTAL_OSC_CTRL_MASK;
            default: wmask = 8'hff;
        endcase
    endfunction

    // One register per generate entry, each decoded on its own address
    genvar gi;
    generate
        for (gi = 1; gi <= 11; gi++) begin : g_cfg
            always_ff @(posedge mclk_in) begin
                if (rst_in || soft_rst) begin
                    cfg_q[gi] <= dflt(gi);
                end else if (wr_in && addr_in == 8'(gi)) begin
                    // Each byte lands alone, so an idle word can be staged
                    cfg_q[gi] <= wdata_in & wmask(gi);
                end
            end
        end
    endgenerate

    // ======================================================================
    // Read path
    // ======================================================================
    // Unmapped offsets read as zero
    always_comb begin
        rd_mux = 8'h00;
        if (addr_in == rtc_pkg::ADDR_MAIN) begin
            rd_mux = main_q;
        end else if (addr_in <= rtc_pkg::ADDR_POWER) begin
            rd_mux = cfg_q[addr_in[3:0]];
        end
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rdata_q <= 8'h00;
        end else if (rd_in) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign rdata_out = rdata_q;

    // ======================================================================
    // Control decode
    // ======================================================================
    // Everything below is straight from flip-flops, so glitch free, except active_word, which is muxed by word select
    always_comb begin
        ctrl_out.word_select             = main_q[rtc_pkg::MAIN_SEL_BIT];
        ctrl_out.transmit_path_powerdown = main_q[rtc_pkg::MAIN_TXPD_BIT];
        ctrl_out.synth_powerdown         = main_q[rtc_pkg::MAIN_FSPD_BIT];
        ctrl_out.osc_core_powerdown      = main_q[rtc_pkg::MAIN_CORE_BIT];
        ctrl_out.bias_powerdown          = main_q[rtc_pkg::MAIN_BIAS_BIT];
        ctrl_out.crystal_bypass          = cfg_q[10][0];
        // Word select steers the synthesiser word
        ctrl_out.active_word = main_q[rtc_pkg::MAIN_SEL_BIT]
                             ? {cfg_q[4], cfg_q[5], cfg_q[6]}
                             : {cfg_q[1], cfg_q[2], cfg_q[3]};
        ctrl_out.deviation        = {cfg_q[7][2:0], cfg_q[8]};
        ctrl_out.osc_core_current = cfg_q[9][7:4];
        ctrl_out.amp_buffer_drive = cfg_q[9][1:0];
        ctrl_out.high_array_level = cfg_q[11][7:4];
        ctrl_out.low_array_level  = cfg_q[11][3:0];
    end

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    sel_word_a: assert property (ctrl_out.word_select |->
        ctrl_out.active_word == {cfg_q[4], cfg_q[5], cfg_q[6]})
        else $error("word select wrong");
    soft_dflt_a: assert property (soft_rst |=>
        cfg_q[1] == rtc_pkg::RST_A_HIGH && cfg_q[6] == rtc_pkg::RST_B_LOW
        && cfg_q[11] == rtc_pkg::RST_POWER)
        else $error("soft reset defaults missing");
    main_write_a: assert property (wr_in && addr_in == rtc_pkg::ADDR_MAIN |=>
        main_q == ($past(wdata_in) & rtc_pkg::MAIN_MASK))
        else $error("main not written");
    txpd_bit_a: assert property (ctrl_out.transmit_path_powerdown == main_q[4]
        && ctrl_out.synth_powerdown == main_q[3])
        else $error("powerdown decode wrong");
    core_bias_a: assert property (ctrl_out.osc_core_powerdown == main_q[2]
        && ctrl_out.bias_powerdown == main_q[1])
        else $error("core or bias decode wrong");
    unused_zero_a: assert property ((main_q & ~rtc_pkg::MAIN_MASK) == 8'h00
        && cfg_q[7][7:3] == 5'h00 && cfg_q[9][3:2] == 2'h0)
        else $error("unused bit set");
    read_once_a: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data outside slot");
    indep_word_a: assert property (wr_in && addr_in == rtc_pkg::ADDR_A_LOW
        && !soft_rst |=> $stable(cfg_q[4]) && $stable(cfg_q[6]))
        else $error("word B disturbed");

    soft_rst_c: cover property (soft_rst ##1 wr_in && addr_in == rtc_pkg::ADDR_MAIN);
    hop_c:      cover property (wr_in && addr_in == rtc_pkg::ADDR_B_LOW ##[1:4] $rose(ctrl_out.word_select));
    read_c:     cover property (rd_in && addr_in == rtc_pkg::ADDR_POWER);
endmodule
`default_nettype wire

// ===== inc/rtc_pkg.sv
`default_nettype none
// ==========================================================================
// Register map and field layout
// ==========================================================================
package rtc_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_MAIN   = 8'h00;
    localparam logic [7:0] ADDR_A_HIGH = 8'h01;
    localparam logic [7:0] ADDR_A_MID  = 8'h02;
    localparam logic [7:0] ADDR_A_LOW  = 8'h03;
    localparam logic [7:0] ADDR_B_HIGH = 8'h04;
    localparam logic [7:0] ADDR_B_MID  = 8'h05;
    localparam logic [7:0] ADDR_B_LOW  = 8'h06;
    localparam logic [7:0] ADDR_DEV_HI = 8'h07;
    localparam logic [7:0] ADDR_DEV_LO = 8'h08;
    localparam logic [7:0] ADDR_BIAS   = 8'h09;
    localparam logic [7:0] ADDR_CRYSTAL_OSC_CTRL   = 8'h0a;
    localparam logic [7:0] ADDR_POWER  = 8'h0b;
    // Main control bit positions
    localparam int MAIN_SEL_BIT   = 6;
    localparam int MAIN_TXPD_BIT  = 4;
    localparam int MAIN_FSPD_BIT  = 3;
    localparam int MAIN_CORE_BIT  = 2;
    localparam int MAIN_BIAS_BIT  = 1;
    localparam int MAIN_RSTN_BIT  = 0;
    // Writable bits of each register with unused holes
    localparam logic [7:0] MAIN_MASK  = 8'h5f;
    localparam logic [7:0] DEVHI_MASK = 8'h07;
    localparam logic [7:0] BIAS_MASK  = 8'hf3;
    localparam logic [7:0] CRYSTAL_OSC_CTRL_MASK  = 8'h01;
    // Reset values
    localparam logic [7:0] RST_A_HIGH = 8'h75;
    localparam logic [7:0] RST_A_MID  = 8'ha0;
    localparam logic [7:0] RST_A_LOW  = 8'hcb;
    localparam logic [7:0] RST_B_HIGH = 8'h75;
    localparam logic [7:0] RST_B_MID  = 8'ha5;
    localparam logic [7:0] RST_B_LOW  = 8'h4e;
    localparam logic [7:0] RST_DEV_HI = 8'h00;
    localparam logic [7:0] RST_DEV_LO = 8'h59;
    localparam logic [7:0] RST_BIAS   = 8'hc2;
    localparam logic [7:0] RST_CRYSTAL_OSC_CTRL   = 8'h00;
    localparam logic [7:0] RST_POWER  = 8'h0f;
    // Main control value after the hardware reset line (bypass default)
    localparam logic [7:0] RST_MAIN   = 8'h00;

    // Decoded controls handed to the analogue blocks
    typedef struct packed {
        logic        word_select;
        logic        transmit_path_powerdown;
        logic        synth_powerdown;
        logic        osc_core_powerdown;
        logic        bias_powerdown;
        logic        crystal_bypass;
        logic [23:0] active_word;
        logic [10:0] deviation;
        logic [3:0]  osc_core_current;
        logic [1:0]  amp_buffer_drive;
        logic [3:0]  high_array_level;
        logic [3:0]  low_array_level;
    } rtc_ctrl_t;
endpackage
`default_nettype wire

// ===== testbench/test_rf_tx_config_registers.sv
`timescale 1ns/10ps
`default_nettype none
module test_rf_tx_config_registers;
    // ====
    // Signals and reference model
    logic               mclk_in;      // 25 MHz bench clock
    logic               rst_in;       // Synchronous reset, high
    logic               wr_in;        // Write strobe
    logic               rd_in;        // Read strobe
    logic [7:0]         addr_in;      // Register offset
    logic [7:0]         wdata_in;     // Write data
    logic [7:0]         rdata_out;    // Read data from the bank
    rtc_pkg::rtc_ctrl_t ctrl_out;     // Decoded controls
    logic [7:0]         m [0:11];     // Model copy of every register
    logic [7:0]         dflt [0:11];  // Values after a reset
    int                 errors;       // Mismatch count
    int                 cmp_count;    // Comparison count
    int                 cyc;          // Cycle counter for the hang guard
    logic [7:0]         a;            // Random offset
    logic [7:0]         d;            // Random data

    rtc_regs rtc_regs_inst (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
                            .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ctrl_out(ctrl_out));

    // ====
    // Helpers
    // Writable bits; holes must stay zero whatever is written
    function automatic logic [7:0] mask(logic [7:0] x);
        return x == 8'h00 ? rtc_pkg::MAIN_MASK : x == 8'h07 ? rtc_pkg::DEVHI_MASK :
               x == 8'h09 ? rtc_pkg::BIAS_MASK : x == 8'h0a ? rtc_pkg::CRYSTAL_OSC_CTRL_MASK : 8'hff;
    endfunction
    task automatic cmp8(string n, logic [7:0] e, logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Controls are pure muxing of the model bytes
    task automatic cmp_ctrl();
        rtc_pkg::rtc_ctrl_t e;
        e = {m[0][6], m[0][4], m[0][3], m[0][2], m[0][1], m[10][0], m[0][6] ? {m[4], m[5], m[6]} :
             {m[1], m[2], m[3]}, m[7][2:0], m[8], m[9][7:4], m[9][1:0], m[11]};
        cmp_count++;
        if (ctrl_out !== e) begin
            errors++;
            $display("[ERR] ctrl_out expected %h seen %h", e, ctrl_out);
        end
    endtask
    // One-cycle write, then model update and control check
    task automatic wr(logic [7:0] x, logic [7:0] v);
        @(posedge mclk_in);
        addr_in  <= x;
        wdata_in <= v;
        wr_in    <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
        // Soft reset leaves main alone but restores the rest
        if (x == 8'h00 && !v[0]) for (int i = 1; i < 12; i++) m[i] = dflt[i];
        if (x < 8'h0c) m[x] = v & mask(x);
        @(negedge mclk_in);
        cmp_ctrl();
    endtask
    // Read data is only looked at in the cycle after the strobe
    task automatic rd(logic [7:0] x);
        @(posedge mclk_in);
        addr_in <= x;
        rd_in   <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        @(negedge mclk_in);
        cmp8("rdata_out", x < 8'h0c ? m[x] : 8'h00, rdata_out);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ====
    // Clock and hang guard
    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end
    // Whole run needs about 900 cycles
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            test_done();
        end
    end

    // ====
    // Main sequence
    initial begin
        rst_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 8'h00;
        wdata_in = 8'h00;
        dflt = '{rtc_pkg::RST_MAIN, rtc_pkg::RST_A_HIGH, rtc_pkg::RST_A_MID, rtc_pkg::RST_A_LOW,
                 rtc_pkg::RST_B_HIGH, rtc_pkg::RST_B_MID, rtc_pkg::RST_B_LOW, rtc_pkg::RST_DEV_HI,
                 rtc_pkg::RST_DEV_LO, rtc_pkg::RST_BIAS, rtc_pkg::RST_CRYSTAL_OSC_CTRL, rtc_pkg::RST_POWER};
        m = dflt;
        void'($urandom(40833));
        repeat (12) @(posedge mclk_in);
        rst_in <= 1'b0;
        // Reset values of every byte, plus two unmapped offsets
        for (int i = 0; i < 14; i++) rd(i < 12 ? 8'(i) : 8'h3f - 8'(i));
        $display("reset values done");
        // Hop: load word B behind select A, then switch; holes and soft reset
        for (int i = 0; i < 8; i++) wr(8'h04 + 8'(i % 3), 8'(i * 37));
        wr(8'h00, 8'hff);
        wr(8'h00, 8'h40);
        wr(8'h00, 8'h41);
        for (int i = 0; i < 12; i++) rd(8'(i));
        $display("hop and soft reset done");
        // Random traffic, soft resets now and then, unmapped writes included
        repeat (200) begin
            a = 8'($urandom % 14);
            if (a > 8'h0b) a = 8'h40 + a;
            d = 8'($urandom);
            wr(a, d);
            rd(8'($urandom % 13));
        end
        $display("random traffic done");
        test_done();
    end
endmodule
`default_nettype wire
